// ### lpmc_ctrl.sv
// Low power mode controller with AHB-Lite register slave
`timescale 1ns/10ps
module lpmc_ctrl
    import lpmc_pkg::*;
(
    // Clock and reset
    input  wire logic              SYS_CLK_I,
    input  wire logic              ARST_N_I,
    // AHB-Lite slave
    input  wire logic              HSEL_I,
    input  wire logic [31:0]       HADDR_I,
    input  wire logic [1:0]        HTRANS_I,
    input  wire logic              HWRITE_I,
    input  wire logic [2:0]        HSIZE_I,
    input  wire logic [31:0]       HWDATA_I,
    input  wire logic              HREADY_I,
    output logic [31:0]            HRDATA_O,
    output logic                   HREADYOUT_O,
    output logic                   HRESP_O,
    // Processor side
    input  wire logic              CPU_WFI_I,
    input  wire logic [IRQ_W-1:0]  IRQ_PENDING_I,
    output logic                   CPU_CLK_EN_O,
    output logic                   CPU_WAKE_O,
    // Wake sources from pins and other domains
    input  wire logic              RST_PIN_N_I,
    input  wire logic              RTC_SECOND_ALARM_FLAG_I,
    input  wire logic              HW_ACTIVITY_WAKE_I,
    input  wire logic              USART_WAKE_I,
    input  wire logic              SPI_WAKE_I,
    input  wire logic              I2C_WAKE_I,
    // Serial operating modes
    input  wire logic              USART_SYNC_SLAVE_I,
    input  wire logic              USART_32K_MODE_I,
    input  wire logic              SPI_SLAVE_I,
    input  wire logic              I2C_SLAVE_I,
    // Clock and power controls
    output logic                   MAIN_CLK_EN_O,
    output logic [PCLK_W-1:0]      PERIPH_CLK_EN_O,
    output logic                   FRO_EN_O,
    output logic                   PLL_EN_O,
    output logic                   RTC_OSC_EN_O,
    output logic                   WD_OSC_EN_O,
    output logic                   FLASH_STANDBY_O,
    output logic                   FLASH_PWR_EN_O,
    output logic [ANA_W-1:0]       ANALOG_PWR_EN_O,
    output logic [KEEP_BLK_W-1:0]  BLOCK_RUN_EN_O,
    output logic                   DMA_EN_O,
    output logic                   CORE_PWR_EN_O,
    output logic                   RETAIN_O,
    output logic                   PIN_HOLD_O,
    output logic                   PIN_TRISTATE_O,
    output logic                   RTC_WAKE_IRQ_O
);

    typedef struct packed {
        lpmc_state_type          state;
        logic [1:0]              mode_sel;
        logic                    armed;
        logic                    keep_fro;
        logic                    keep_rtcosc;
        logic                    keep_wdosc;
        logic [KEEP_BLK_W-1:0]   keep_blk;
        logic [ANA_W-1:0]        ana_wake;
        logic [IRQ_W-1:0]        wake_start;
        logic [PCLK_W-1:0]       periph_en;
        logic                    dma_ds;
        logic [2:0]              cause;
        logic                    wake_pulse;
        logic                    rtc_irq;
        logic                    dp_valid;
        logic                    dp_write;
        logic [4:0]              dp_addr;
    } lpmc_state_reg_type;

    localparam lpmc_state_reg_type RESET_STATE = '{
        state:       ST_ACTIVE,
        mode_sel:    MODE_ACTIVE,
        armed:       1'b0,
        keep_fro:    1'b0,
        keep_rtcosc: 1'b0,
        keep_wdosc:  1'b0,
        keep_blk:    '0,
        ana_wake:    '0,
        wake_start:  RST_WAKE_START,
        periph_en:   RST_PERIPH_CLK,
        dma_ds:      1'b0,
        cause:       CAUSE_NONE,
        wake_pulse:  1'b0,
        rtc_irq:     1'b0,
        dp_valid:    1'b0,
        dp_write:    1'b0,
        dp_addr:     5'h00
    };

    lpmc_state_reg_type st_reg;
    lpmc_state_reg_type st_next;
    lpmc_sync_if        sy_if ();

    logic              rst_n;
    logic              rst_pin;
    logic              rtc_flag;
    logic              hw_wake;
    logic              serial_wake;
    logic              sleep_wake;
    logic              ds_wake;
    logic              dpd_wake;
    logic [2:0]        wake_cause;
    logic              addr_phase;

    // Input synchroniser and reset release
    assign sy_if.clk                = SYS_CLK_I;
    assign sy_if.arst_n             = ARST_N_I;
    assign sy_if.raw[SY_RST_PIN]    = ~RST_PIN_N_I;
    assign sy_if.raw[SY_RTC]        = RTC_SECOND_ALARM_FLAG_I;
    assign sy_if.raw[SY_HW]         = HW_ACTIVITY_WAKE_I;
    assign sy_if.raw[SY_USART]      = USART_WAKE_I;
    assign sy_if.raw[SY_SPI]        = SPI_WAKE_I;
    assign sy_if.raw[SY_I2C]        = I2C_WAKE_I;

    lpmc_sync u_sync (
        .sy (sy_if.sync)
    );

    assign rst_n    = sy_if.rst_n;
    assign rst_pin  = sy_if.stable[SY_RST_PIN];
    assign rtc_flag = sy_if.stable[SY_RTC];
    assign hw_wake  = sy_if.stable[SY_HW];

    // Map state to the software mode code
    function automatic logic [1:0] state_mode(input lpmc_state_type s);
        logic [1:0] m;
        m = MODE_ACTIVE;
        unique case (s)
            ST_ACTIVE:     m = MODE_ACTIVE;
            ST_SLEEP:      m = MODE_SLEEP;
            ST_DEEP_SLEEP: m = MODE_DEEP_SLEEP;
            ST_POWER_DOWN: m = MODE_POWER_DOWN;
        endcase
        return m;
    endfunction

    // Register read decode
    function automatic logic [31:0] reg_read(input lpmc_state_reg_type r, input logic [4:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            OFS_MODE_CTRL: begin
                d[MODE_LSB +: 2] = r.mode_sel;
                d[ARMED_BIT]     = r.armed;
            end
            OFS_DS_KEEP: begin
                d[KEEP_FRO_BIT]               = r.keep_fro;
                d[KEEP_RTCOSC_BIT]            = r.keep_rtcosc;
                d[KEEP_WDOSC_BIT]             = r.keep_wdosc;
                d[KEEP_BLK_LSB +: KEEP_BLK_W] = r.keep_blk;
                d[ANA_LSB +: ANA_W]           = r.ana_wake;
            end
            OFS_WAKE_START: d = r.wake_start;
            OFS_PERIPH_CLK: d = r.periph_en;
            OFS_STATUS: begin
                d[1:0] = state_mode(r.state);
                d[4:2] = r.cause;
                d[5]   = r.rtc_irq;
            end
            OFS_DMA_DS:     d[0] = r.dma_ds;
            default:        d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Serial slave or USART 32K mode wakes in deep-sleep
    assign serial_wake = (sy_if.stable[SY_USART] & (USART_SYNC_SLAVE_I | USART_32K_MODE_I))
                       | (sy_if.stable[SY_SPI] & SPI_SLAVE_I)
                       | (sy_if.stable[SY_I2C] & I2C_SLAVE_I);

    // Interrupt lines arrive already gated by the interrupt controller enables
    assign sleep_wake = (|IRQ_PENDING_I) | rst_pin | hw_wake | rtc_flag;
    assign ds_wake    = (|(IRQ_PENDING_I & st_reg.wake_start))
                      | rst_pin | hw_wake | serial_wake
                      | (rtc_flag & st_reg.keep_blk[BLK_RTC]);
    assign dpd_wake   = rst_pin | rtc_flag;

    // Wake cause priority
    always_comb begin
        wake_cause = CAUSE_IRQ;
        if (rst_pin) begin
            wake_cause = CAUSE_RST;
        end else if (rtc_flag) begin
            wake_cause = CAUSE_RTC;
        end else if (hw_wake) begin
            wake_cause = CAUSE_HW;
        end else if (serial_wake && st_reg.state == ST_DEEP_SLEEP) begin
            wake_cause = CAUSE_SLAVE;
        end
    end

    assign addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;

    always_comb begin
        st_next            = st_reg;
        st_next.wake_pulse = 1'b0;
        st_next.rtc_irq    = rtc_flag;

        // Address phase capture
        st_next.dp_valid = addr_phase;
        st_next.dp_write = addr_phase & HWRITE_I;
        st_next.dp_addr  = {HADDR_I[4:2], 2'b00};

        // Data phase write
        if (st_reg.dp_valid && st_reg.dp_write) begin
            unique case (st_reg.dp_addr)
                OFS_MODE_CTRL: begin
                    st_next.mode_sel = HWDATA_I[MODE_LSB +: 2];
                    st_next.armed    = HWDATA_I[ARMED_BIT];
                end
                OFS_DS_KEEP: begin
                    st_next.keep_fro    = HWDATA_I[KEEP_FRO_BIT];
                    st_next.keep_rtcosc = HWDATA_I[KEEP_RTCOSC_BIT];
                    st_next.keep_wdosc  = HWDATA_I[KEEP_WDOSC_BIT];
                    st_next.keep_blk    = HWDATA_I[KEEP_BLK_LSB +: KEEP_BLK_W];
                    st_next.ana_wake    = HWDATA_I[ANA_LSB +: ANA_W];
                end
                OFS_WAKE_START: st_next.wake_start = HWDATA_I;
                OFS_PERIPH_CLK: st_next.periph_en  = HWDATA_I;
                OFS_DMA_DS:     st_next.dma_ds     = HWDATA_I[0];
                default: begin
                end
            endcase
        end

        // Mode sequencing
        unique case (st_reg.state)
            ST_ACTIVE: begin
                if (st_reg.armed && CPU_WFI_I && st_reg.mode_sel != MODE_ACTIVE) begin
                    st_next.armed = 1'b0;
                    unique case (st_reg.mode_sel)
                        MODE_SLEEP:      st_next.state = ST_SLEEP;
                        MODE_DEEP_SLEEP: st_next.state = ST_DEEP_SLEEP;
                        MODE_POWER_DOWN: st_next.state = ST_POWER_DOWN;
                        default:         st_next.state = ST_ACTIVE;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (sleep_wake) begin
                    st_next.state      = ST_ACTIVE;
                    st_next.wake_pulse = 1'b1;
                    st_next.cause      = wake_cause;
                end
            end
            ST_DEEP_SLEEP: begin
                if (ds_wake) begin
                    st_next.state      = ST_ACTIVE;
                    st_next.wake_pulse = 1'b1;
                    st_next.cause      = wake_cause;
                end
            end
            ST_POWER_DOWN: begin
                if (dpd_wake) begin
                    // Nothing survives power-down but the wake cause
                    st_next            = RESET_STATE;
                    st_next.rtc_irq    = rtc_flag;
                    st_next.wake_pulse = 1'b1;
                    st_next.cause      = rst_pin ? CAUSE_RST : CAUSE_RTC;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= RESET_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus answers: zero wait, always OKAY
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = (st_reg.dp_valid && !st_reg.dp_write) ? reg_read(st_reg, st_reg.dp_addr) : 32'h0000_0000;

    // Power and clock outputs
    always_comb begin
        CPU_CLK_EN_O    = 1'b1;
        MAIN_CLK_EN_O   = 1'b1;
        PERIPH_CLK_EN_O = st_reg.periph_en;
        FRO_EN_O        = 1'b1;
        PLL_EN_O        = 1'b1;
        RTC_OSC_EN_O    = 1'b1;
        WD_OSC_EN_O     = 1'b1;
        FLASH_STANDBY_O = 1'b0;
        FLASH_PWR_EN_O  = 1'b1;
        ANALOG_PWR_EN_O = '1;
        BLOCK_RUN_EN_O  = '1;
        DMA_EN_O        = 1'b1;
        CORE_PWR_EN_O   = 1'b1;
        RETAIN_O        = 1'b0;
        PIN_HOLD_O      = 1'b0;
        PIN_TRISTATE_O  = 1'b0;
        unique case (st_reg.state)
            ST_ACTIVE: begin
            end
            ST_SLEEP: begin
                CPU_CLK_EN_O = 1'b0;
                RETAIN_O     = 1'b1;
                PIN_HOLD_O   = 1'b1;
            end
            ST_DEEP_SLEEP: begin
                CPU_CLK_EN_O    = 1'b0;
                MAIN_CLK_EN_O   = 1'b0;
                PERIPH_CLK_EN_O = '0;
                FRO_EN_O        = st_reg.keep_fro;
                PLL_EN_O        = 1'b0;
                RTC_OSC_EN_O    = st_reg.keep_rtcosc;
                WD_OSC_EN_O     = st_reg.keep_wdosc;
                FLASH_STANDBY_O = 1'b1;
                ANALOG_PWR_EN_O = st_reg.ana_wake;
                BLOCK_RUN_EN_O  = st_reg.keep_blk;
                DMA_EN_O        = st_reg.dma_ds;
                RETAIN_O        = 1'b1;
                PIN_HOLD_O      = 1'b1;
            end
            ST_POWER_DOWN: begin
                CPU_CLK_EN_O    = 1'b0;
                MAIN_CLK_EN_O   = 1'b0;
                PERIPH_CLK_EN_O = '0;
                FRO_EN_O        = 1'b0;
                PLL_EN_O        = 1'b0;
                RTC_OSC_EN_O    = st_reg.keep_rtcosc;
                WD_OSC_EN_O     = 1'b0;
                FLASH_PWR_EN_O  = 1'b0;
                ANALOG_PWR_EN_O = '0;
                BLOCK_RUN_EN_O  = '0;
                DMA_EN_O        = 1'b0;
                CORE_PWR_EN_O   = 1'b0;
                PIN_TRISTATE_O  = 1'b1;
            end
        endcase
    end

    assign CPU_WAKE_O     = st_reg.wake_pulse;
    assign RTC_WAKE_IRQ_O = st_reg.rtc_irq;

endmodule // lpmc_ctrl

// ### lpmc_pkg.sv
// Package for the low power mode controller: register map, fields, states
package lpmc_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_MODE_CTRL   = 5'h00;
    localparam logic [4:0] OFS_DS_KEEP     = 5'h04;
    localparam logic [4:0] OFS_WAKE_START  = 5'h08;
    localparam logic [4:0] OFS_PERIPH_CLK  = 5'h0C;
    localparam logic [4:0] OFS_STATUS      = 5'h10;
    localparam logic [4:0] OFS_DMA_DS      = 5'h14;

    // Mode codes
    localparam logic [1:0] MODE_ACTIVE     = 2'h0;
    localparam logic [1:0] MODE_SLEEP      = 2'h1;
    localparam logic [1:0] MODE_DEEP_SLEEP = 2'h2;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h3;

    // Mode control fields
    localparam int MODE_LSB    = 0;
    localparam int ARMED_BIT   = 2;

    // Deep-sleep keep fields
    localparam int KEEP_FRO_BIT    = 0;
    localparam int KEEP_RTCOSC_BIT = 1;
    localparam int KEEP_WDOSC_BIT  = 2;
    localparam int KEEP_BLK_LSB    = 8;
    localparam int KEEP_BLK_W      = 9;
    localparam int ANA_LSB         = 20;
    localparam int ANA_W           = 4;

    // Kept block order within the keep field
    localparam int BLK_PIN_INT  = 0;
    localparam int BLK_GRP_INT  = 1;
    localparam int BLK_USB      = 2;
    localparam int BLK_MIC      = 3;
    localparam int BLK_SERIAL   = 4;
    localparam int BLK_WDT      = 5;
    localparam int BLK_RTC      = 6;
    localparam int BLK_UTICK    = 7;
    localparam int BLK_BROWNOUT = 8;

    // Widths
    localparam int IRQ_W    = 32;
    localparam int PCLK_W   = 32;
    localparam int SYNC_W   = 6;

    // Synchronised input order
    localparam int SY_RST_PIN = 0;
    localparam int SY_RTC     = 1;
    localparam int SY_HW      = 2;
    localparam int SY_USART   = 3;
    localparam int SY_SPI     = 4;
    localparam int SY_I2C     = 5;

    // Wake cause codes
    localparam logic [2:0] CAUSE_NONE  = 3'h0;
    localparam logic [2:0] CAUSE_IRQ   = 3'h1;
    localparam logic [2:0] CAUSE_RST   = 3'h2;
    localparam logic [2:0] CAUSE_RTC   = 3'h3;
    localparam logic [2:0] CAUSE_HW    = 3'h4;
    localparam logic [2:0] CAUSE_SLAVE = 3'h5;

    // Reset values
    localparam logic [31:0] RST_WAKE_START = 32'h0000_0000;
    localparam logic [31:0] RST_PERIPH_CLK = 32'hFFFF_FFFF;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_DEEP_SLEEP,
        ST_POWER_DOWN
    } lpmc_state_type;

endpackage

// ### lpmc_sync_if.sv
// Interface between the controller and its input synchroniser
`timescale 1ns/10ps
interface lpmc_sync_if;
    import lpmc_pkg::*;
    logic              clk;
    logic              arst_n;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] stable;
    logic              rst_n;

    modport sync (input clk, input arst_n, input raw, output stable, output rst_n);
    modport core (output clk, output arst_n, output raw, input stable, input rst_n);
endinterface

// ### lpmc_sync.sv
// Reset release and three-stage input synchroniser
`timescale 1ns/10ps
module lpmc_sync
    import lpmc_pkg::*;
(
    lpmc_sync_if.sync sy
);

    typedef struct packed {
        logic [1:0]        rst_sh;
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] stable;
    } lpmc_sync_state_type;

    lpmc_sync_state_type st_reg;
    lpmc_sync_state_type st_next;
    logic [SYNC_W-1:0]   agree_val;

    // Accept a change once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_agree
            assign agree_val[g] = (st_reg.s2[g] == st_reg.s3[g]) ? st_reg.s3[g] : st_reg.stable[g];
        end
    endgenerate

    always_comb begin
        st_next        = st_reg;
        st_next.rst_sh = {st_reg.rst_sh[0], 1'b1};
        st_next.s1     = sy.raw;
        st_next.s2     = st_reg.s1;
        st_next.s3     = st_reg.s2;
        st_next.stable = agree_val;
    end

    always_ff @(posedge sy.clk or negedge sy.arst_n) begin
        if (!sy.arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sy.rst_n  = st_reg.rst_sh[1];
    assign sy.stable = st_reg.stable;

endmodule // lpmc_sync

// ### lpmc_ctrl_checker.sv
// Port checker for the low power mode controller
`timescale 1ns/10ps
module lpmc_ctrl_checker
    import lpmc_pkg::*;
(
    // Clock, reset and inputs
    input wire logic              SYS_CLK_I,
    input wire logic              ARST_N_I,
    input wire logic              CPU_WFI_I,
    input wire logic [IRQ_W-1:0]  IRQ_PENDING_I,
    input wire logic              RST_PIN_N_I,
    input wire logic              RTC_SECOND_ALARM_FLAG_I,
    // Observed outputs
    input wire logic              CPU_CLK_EN_O,
    input wire logic              CPU_WAKE_O,
    input wire logic              MAIN_CLK_EN_O,
    input wire logic [PCLK_W-1:0] PERIPH_CLK_EN_O,
    input wire logic              PLL_EN_O,
    input wire logic              WD_OSC_EN_O,
    input wire logic              FLASH_PWR_EN_O,
    input wire logic              FLASH_STANDBY_O,
    input wire logic              CORE_PWR_EN_O,
    input wire logic              RETAIN_O,
    input wire logic              PIN_HOLD_O,
    input wire logic              PIN_TRISTATE_O,
    input wire logic              RTC_WAKE_IRQ_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // Sleep state seen at the ports
    logic slp;
    assign slp = !CPU_CLK_EN_O && RETAIN_O && !FLASH_STANDBY_O;

    stay_active_a: assert property (CPU_CLK_EN_O && !CPU_WFI_I |=> CPU_CLK_EN_O)
        else $error("left active without wait");
    entry_wfi_a: assert property ($fell(CPU_CLK_EN_O) |-> $past(CPU_WFI_I))
        else $error("entry without wait");
    retain_a: assert property (!CPU_CLK_EN_O && CORE_PWR_EN_O |-> RETAIN_O && PIN_HOLD_O)
        else $error("state not retained");
    deep_gate_a: assert property (FLASH_STANDBY_O |-> !CPU_CLK_EN_O && !MAIN_CLK_EN_O && !PLL_EN_O)
        else $error("deep sleep clocks running");
    deep_periph_a: assert property (FLASH_STANDBY_O |-> ~|PERIPH_CLK_EN_O)
        else $error("deep sleep peripheral clock");
    pdn_off_a: assert property (PIN_TRISTATE_O |-> !CORE_PWR_EN_O && !RETAIN_O && !MAIN_CLK_EN_O)
        else $error("power down not off");
    pdn_flash_a: assert property (PIN_TRISTATE_O |-> !FLASH_PWR_EN_O && !WD_OSC_EN_O)
        else $error("power down flash powered");
    pdn_stay_a: assert property ((PIN_TRISTATE_O && RST_PIN_N_I && !RTC_SECOND_ALARM_FLAG_I) [*6] |=> PIN_TRISTATE_O)
        else $error("power down left without cause");
    wake_pulse_a: assert property (CPU_WAKE_O |-> (CPU_CLK_EN_O && !$past(CPU_CLK_EN_O)) ##1 !CPU_WAKE_O)
        else $error("wake pulse wrong");
    irq_wake_a: assert property (slp && |IRQ_PENDING_I |-> ##[1:2] CPU_CLK_EN_O)
        else $error("interrupt did not end sleep");
    rtc_irq_a: assert property ($rose(RTC_SECOND_ALARM_FLAG_I) && CPU_CLK_EN_O |-> ##[2:6] RTC_WAKE_IRQ_O)
        else $error("alarm request missing");

    sleep_c: cover property (slp);
    deep_c: cover property (FLASH_STANDBY_O);
    pdn_c: cover property (PIN_TRISTATE_O);
endmodule // lpmc_ctrl_checker

bind lpmc_ctrl lpmc_ctrl_checker u_checker (.*);

// ### lpmc_core_model.sv
// Processor core model: wait-for-interrupt and enabled interrupt lines
`timescale 1ns/10ps
module lpmc_core_model (
    // Clock and requests
    input  wire logic        clk_i,
    input  wire logic        clk_en_i,
    input  wire logic        go_i,
    input  wire logic [31:0] irq_i,
    input  wire logic [31:0] irq_en_i,
    // To the controller
    output logic             wfi_o,
    output logic [31:0]      pend_o
);
    // Only lines enabled in the nested_irq_controller reach the block
    assign pend_o = irq_i & irq_en_i;
    // Wait state frozen while the core clock is stopped
    always_ff @(posedge clk_i) begin
        if (clk_en_i) begin
            wfi_o <= go_i;
        end
    end
endmodule // lpmc_core_model

// ### low_power_mode_controller_bench.sv
// Self-checking bench for the low power mode controller
`timescale 1ns/10ps
module low_power_mode_controller_bench
    import lpmc_pkg::*;
;
    typedef struct packed {
        logic [1:0]  mode;
        logic [31:0] keep;
        logic [1:0]  how;
        logic [2:0]  cause;
        logic [10:0] exp;
    } lpmc_row_type;
    // Mode, kept set, wake source, cause, low power outputs
    localparam lpmc_row_type ROWS [5] = '{
        '{MODE_SLEEP, 32'h0000_0000, 2'h0, CAUSE_IRQ, 11'h35F},
        '{MODE_SLEEP, 32'h0000_0000, 2'h2, CAUSE_HW, 11'h35F},
        '{MODE_DEEP_SLEEP, 32'h0050_0001, 2'h0, CAUSE_IRQ, 11'h1C5},
        '{MODE_DEEP_SLEEP, 32'h0000_4000, 2'h1, CAUSE_RTC, 11'h0C0},
        '{MODE_POWER_DOWN, 32'h0000_0000, 2'h1, CAUSE_RTC, 11'h020}};
    logic        clk, arst_n, hsel, hwrite, go, rtc, hw, ser, slave, m32, rst_pin, rdy, wfi;
    logic        cpu_en, main_en, fro, stby, ret, flt, dma, hresp;
    logic [8:0]  blk, bx;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  ana;
    logic [31:0] haddr, hwdata, hrdata, irq, nen, pend, pclk, q;
    int          n_errors, comparisons;

    lpmc_core_model u_core (.clk_i(clk), .clk_en_i(cpu_en), .go_i(go), .irq_i(irq), .irq_en_i(nen),
        .wfi_o(wfi), .pend_o(pend));
    lpmc_ctrl DUT (
        .SYS_CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(rdy), .HRDATA_O(hrdata),
        .HREADYOUT_O(rdy), .HRESP_O(hresp), .CPU_WFI_I(wfi), .IRQ_PENDING_I(pend), .CPU_CLK_EN_O(cpu_en),
        .CPU_WAKE_O(), .RST_PIN_N_I(rst_pin), .RTC_SECOND_ALARM_FLAG_I(rtc), .HW_ACTIVITY_WAKE_I(hw),
        .USART_WAKE_I(ser), .SPI_WAKE_I(ser), .I2C_WAKE_I(ser), .USART_SYNC_SLAVE_I(slave),
        .USART_32K_MODE_I(m32), .SPI_SLAVE_I(slave), .I2C_SLAVE_I(slave), .MAIN_CLK_EN_O(main_en),
        .PERIPH_CLK_EN_O(pclk), .FRO_EN_O(fro), .PLL_EN_O(), .RTC_OSC_EN_O(), .WD_OSC_EN_O(),
        .FLASH_STANDBY_O(stby), .FLASH_PWR_EN_O(), .ANALOG_PWR_EN_O(ana), .BLOCK_RUN_EN_O(blk),
        .DMA_EN_O(dma), .CORE_PWR_EN_O(), .RETAIN_O(ret), .PIN_HOLD_O(), .PIN_TRISTATE_O(flt),
        .RTC_WAKE_IRQ_O());

    task automatic stop_test();
        $display("Errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask

    // Bounded wait on ready (s=0) or processor clock (s=1)
    task automatic wt(input logic s, input logic v);
        int n;
        n = 0;
        while ((s ? cpu_en : rdy) !== v) begin
            n++;
            if (n > 60) begin
                $display("[ERR] wait expected %b seen %b", v, s ? cpu_en : rdy);
                n_errors++;
                stop_test();
            end
            @(posedge clk);
        end
    endtask

    task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {27'h0, a};
        hwrite <= w;
        @(posedge clk);
        wt(1'b0, 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        wt(1'b0, 1'b1);
        r = hrdata;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0000_0000, r);
        chk("register read", e, r);
        chk("response", 32'h0000_0000, {31'h0, hresp});
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        {arst_n, hsel, hwrite, go, rtc, hw, ser, slave, m32} = 9'h000;
        rst_pin = 1'b1;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        irq = 32'h0000_0000;
        nen = 32'hFFFF_FFFF;
        n_errors = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("clock enable port", 32'hFFFF_FFFF, pclk);
        rd(OFS_PERIPH_CLK, 32'hFFFF_FFFF);
        rd(OFS_WAKE_START, 32'h0000_0000);
        rd(5'h1C, 32'h0000_0000);
        rtc <= 1'b1;
        repeat (8) @(posedge clk);
        rd(OFS_STATUS, 32'h0000_0020);
        rtc <= 1'b0;
        ahb(1'b1, OFS_PERIPH_CLK, 32'h0000_00A5, q);
        foreach (ROWS[i]) begin
            ahb(1'b1, OFS_DS_KEEP, ROWS[i].keep, q);
            ahb(1'b1, OFS_WAKE_START, 32'h0000_0001, q);
            ahb(1'b1, OFS_MODE_CTRL, {29'h0, 1'b1, ROWS[i].mode}, q);
            go <= 1'b1;
            wt(1'b1, 1'b0);
            go <= 1'b0;
            @(posedge clk);
            chk("low power outputs", {21'h0, ROWS[i].exp}, {21'h0, cpu_en, main_en, fro, stby, ret, flt, dma, ana});
            chk("peripheral clocks", (ROWS[i].mode == MODE_SLEEP) ? 32'h0000_00A5 : 32'h0000_0000, pclk);
            bx = (ROWS[i].mode == MODE_SLEEP) ? 9'h1FF : ROWS[i].keep[16:8];
            chk("kept blocks", (ROWS[i].mode == MODE_POWER_DOWN) ? 32'h0000_0000 : {23'h0, bx}, {23'h0, blk});
            repeat (6) @(posedge clk);
            irq[0] <= (ROWS[i].how == 2'h0);
            rtc <= (ROWS[i].how == 2'h1);
            hw <= (ROWS[i].how == 2'h2);
            wt(1'b1, 1'b1);
            {irq[0], rtc, hw} <= 3'h0;
            repeat (5) @(posedge clk);
            ahb(1'b0, OFS_STATUS, 32'h0000_0000, q);
            chk("wake cause", {29'h0, ROWS[i].cause}, {29'h0, q[4:2]});
        end
        for (int k = 1; k < 5; k += 3) begin
            ahb(1'b1, OFS_MODE_CTRL, 32'(k), q);
            go <= 1'b1;
            repeat (8) @(posedge clk);
            chk("clock without arm", 32'h0000_0001, {31'h0, cpu_en});
            go <= 1'b0;
        end
        ahb(1'b1, OFS_DMA_DS, 32'h0000_0001, q);
        for (int j = 0; j < 2; j++) begin
            ahb(1'b1, OFS_MODE_CTRL, 32'h0000_0006, q);
            go <= 1'b1;
            wt(1'b1, 1'b0);
            go <= 1'b0;
            irq[1] <= 1'b1;
            ser <= 1'b1;
            repeat (12) @(posedge clk);
            chk("masked wake", 32'h0000_0000, {31'h0, cpu_en});
            chk("deep dma", 32'h0000_0001, {31'h0, dma});
            m32 <= (j == 0);
            slave <= (j == 1);
            wt(1'b1, 1'b1);
            {irq[1], ser, slave, m32} <= 4'h0;
            ahb(1'b0, OFS_STATUS, 32'h0000_0000, q);
            chk("slave wake cause", {29'h0, CAUSE_SLAVE}, {29'h0, q[4:2]});
        end
        // Reset in mid-run while asleep
        ahb(1'b1, OFS_MODE_CTRL, 32'h0000_0005, q);
        go <= 1'b1;
        wt(1'b1, 1'b0);
        go <= 1'b0;
        arst_n <= 1'b0;
        @(posedge clk);
        chk("clock in reset", 32'h0000_0001, {31'h0, cpu_en});
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFS_MODE_CTRL, 32'h0000_0000);
        stop_test();
    end
endmodule // low_power_mode_controller_bench
